// File: logic/tdh_desc_store.sv
`timescale 1ns/1ps
module tdh_desc_store
    import tdh_pkg::*;
#(
    parameter int WORDS = DESC_WORDS,
    parameter int WIDTH = 32
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [$clog2(WORDS)-1:0] wr_idx_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [$clog2(WORDS)-1:0] rd_idx_in,
    output logic [WIDTH-1:0] rd_data_out
);
    // refuse sizes the index and data paths cannot serve
    if (WORDS < 2 || WIDTH < 1) begin : g_bad_size
        $error("tdh_desc_store: WORDS must be at least 2 and WIDTH at least 1");
    end

    typedef struct packed {
        logic [WORDS-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } tdh_store_s;

    tdh_store_s r;
    tdh_store_s next_r;

    always_comb begin
        next_r = r;
        if (wr_en_in) begin
            next_r.mem[wr_idx_in] = wr_data_in;
        end
        next_r.rdata = r.mem[rd_idx_in];
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data_out = r.rdata;

endmodule : tdh_desc_store

// File: logic/tdh_pkg.sv
package tdh_pkg;

    // ****************************************
    // register map of the slave port
    // ****************************************
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_POLL = 8'h04;
    localparam logic [7:0] REG_DESC_PTR = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam logic [7:0] REG_LAST_STATUS = 8'h18;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_EMPTY_BIT = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [31:0] DESC_PTR_RESET = 32'h0000_0000;

    // ****************************************
    // descriptor layout in system memory
    // ****************************************
    localparam int DESC_WORDS = 4;
    localparam logic [31:0] TX_DESC_STATUS_OFS = 32'h0000_0000;
    localparam logic [31:0] TX_DESC_CONTROL_OFS = 32'h0000_0004;
    localparam logic [31:0] TX_DESC_BUFFER1_PTR_OFS = 32'h0000_0008;
    localparam logic [31:0] TX_DESC_BUFFER2_PTR_OFS = 32'h0000_000C;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] DESC_ALIGN_MASK = 32'hFFFF_FFFC;

    // status word fields
    localparam int OWN_BIT = 31;
    localparam int UR_LSB = 22;
    localparam int ERROR_SUMMARY_BIT = 15;
    localparam int JABBER_TIMEOUT_BIT = 14;
    localparam int CARRIER_DROPPED_BIT = 11;
    localparam int NO_CARRIER_BIT = 10;
    localparam int LATE_COLLISION_BIT = 9;
    localparam int EXCESS_COLLISION_BIT = 8;
    localparam int HEARTBEAT_FAIL_BIT = 7;
    localparam int CC_LSB = 3;
    localparam int UNDERRUN_ERROR_BIT = 1;
    localparam int DEFERRED_BIT = 0;

    // control word fields
    localparam int IC_BIT = 31;
    localparam int LS_BIT = 30;
    localparam int FS_BIT = 29;
    localparam int CRC_APPEND_DISABLE_BIT = 26;
    localparam int END_OF_RING_BIT = 25;
    localparam int NEXT_POINTER_CHAIN_BIT = 24;
    localparam int PAD_DISABLE_BIT = 23;
    localparam int TBS_W = 11;
    localparam int TBS2_LSB = 11;
    localparam int TBS1_LSB = 0;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_FETCH = 6'b000010,
        ST_LOAD = 6'b000100,
        ST_SEND = 6'b001000,
        ST_STAT = 6'b010000,
        ST_RELEASE = 6'b100000
    } tdh_state_e;

endpackage : tdh_pkg

// File: logic/tdh_tx_desc.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module tdh_tx_desc
    import tdh_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in,
    output logic tx_start_out,
    output logic [31:0] buffer_one_pointer_out,
    output logic [31:0] buffer_two_pointer_out,
    output logic [TBS_W-1:0] buffer_one_size_out,
    output logic [TBS_W-1:0] buffer_two_size_out,
    output logic buffer_two_valid_out,
    output logic crc_append_out,
    output logic pad_enable_out,
    output logic first_desc_out,
    output logic last_desc_out,
    input wire logic tx_done_in,
    input wire logic underrun_error_in,
    input wire logic [1:0] underrun_count_in,
    input wire logic excess_collision_in,
    input wire logic late_collision_in,
    input wire logic no_carrier_in,
    input wire logic carrier_dropped_in,
    input wire logic jabber_timeout_in,
    input wire logic heartbeat_fail_in,
    input wire logic [3:0] collision_count_in,
    input wire logic deferred_in
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        tdh_state_e state;
        logic enable;
        logic poll_pend;
        logic [31:0] desc_ptr;
        logic [1:0] word_idx;
        logic [2:0] load_cnt;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic mem_req;
        logic mem_write;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic tx_start;
        logic [31:0] ctrl;
        logic [31:0] ba1;
        logic [31:0] ba2;
        logic crc_append;
        logic pad_enable;
        logic buf2_valid;
        logic [31:0] status;
    } tdh_core_s;

    tdh_core_s r;
    tdh_core_s next_r;

    logic store_wr;
    logic [1:0] store_rd_idx;
    logic [31:0] store_rd_data;

    // ****************************************
    // status word assembly
    // ****************************************
    function automatic logic [31:0] build_status(
        input logic uf,
        input logic [1:0] ur,
        input logic ec,
        input logic lc,
        input logic nc,
        input logic lo,
        input logic jt,
        input logic hf,
        input logic [3:0] cc,
        input logic de
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[UR_LSB +: 2] = ur;
        w[ERROR_SUMMARY_BIT] = uf | ec | lc | nc | lo | jt;
        w[JABBER_TIMEOUT_BIT] = jt;
        w[CARRIER_DROPPED_BIT] = lo;
        w[NO_CARRIER_BIT] = nc;
        w[LATE_COLLISION_BIT] = lc;
        w[EXCESS_COLLISION_BIT] = ec;
        w[HEARTBEAT_FAIL_BIT] = hf;
        w[CC_LSB +: 4] = cc;
        w[UNDERRUN_ERROR_BIT] = uf;
        w[DEFERRED_BIT] = de;
        return w;
    endfunction : build_status

    // descriptor pointer with the low two bits forced to zero
    function automatic logic [31:0] align_desc(input logic [31:0] ptr);
        return ptr & DESC_ALIGN_MASK;
    endfunction : align_desc

    // ****************************************
    // descriptor store
    // ****************************************
    tdh_desc_store #(
        .WORDS(DESC_WORDS),
        .WIDTH(32)
    ) u_store (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .wr_en_in(store_wr),
        .wr_idx_in(r.word_idx),
        .wr_data_in(mem_rdata_in),
        .rd_idx_in(store_rd_idx),
        .rd_data_out(store_rd_data)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [IRQ_W-1:0] ev;
        ev = '0;
        next_r = r;
        store_wr = 1'b0;
        store_rd_idx = r.load_cnt[1:0];
        next_r.tx_start = 1'b0;
        next_r.rdata = 32'h0000_0000;

        unique case (r.state)
            ST_IDLE: begin
                if (r.enable && r.poll_pend) begin
                    next_r.poll_pend = 1'b0;
                    next_r.state = ST_FETCH;
                    next_r.word_idx = 2'h0;
                    next_r.mem_req = 1'b1;
                    next_r.mem_write = 1'b0;
                    next_r.mem_addr = r.desc_ptr + TX_DESC_STATUS_OFS;
                end
            end
            ST_FETCH: begin
                if (mem_ack_in) begin
                    store_wr = 1'b1;
                    if (r.word_idx == 2'h0 && !mem_rdata_in[OWN_BIT]) begin
                        next_r.mem_req = 1'b0;
                        ev[IRQ_EMPTY_BIT] = 1'b1;
                        next_r.state = ST_IDLE;
                    end else if (r.word_idx == 2'h3) begin
                        next_r.mem_req = 1'b0;
                        next_r.load_cnt = 3'h1;
                        next_r.state = ST_LOAD;
                    end else begin
                        next_r.word_idx = r.word_idx + 2'h1;
                        next_r.mem_addr = r.mem_addr + WORD_STEP;
                    end
                end
            end
            ST_LOAD: begin
                // store answers one cycle after the index
                next_r.load_cnt = r.load_cnt + 3'h1;
                if (r.load_cnt == 3'h2) begin
                    next_r.ctrl = store_rd_data;
                    next_r.crc_append = !store_rd_data[CRC_APPEND_DISABLE_BIT];
                    next_r.pad_enable = !store_rd_data[PAD_DISABLE_BIT];
                    next_r.buf2_valid = !store_rd_data[NEXT_POINTER_CHAIN_BIT];
                end
                if (r.load_cnt == 3'h3) begin
                    next_r.ba1 = store_rd_data;
                end
                if (r.load_cnt == 3'h4) begin
                    next_r.ba2 = store_rd_data;
                    next_r.tx_start = 1'b1;
                    next_r.state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_done_in) begin
                    next_r.status = build_status(underrun_error_in, underrun_count_in, excess_collision_in,
                        late_collision_in, no_carrier_in, carrier_dropped_in, jabber_timeout_in,
                        heartbeat_fail_in, collision_count_in, deferred_in);
                    next_r.mem_req = 1'b1;
                    next_r.mem_write = 1'b1;
                    next_r.mem_addr = r.desc_ptr + TX_DESC_STATUS_OFS;
                    next_r.mem_wdata = next_r.status;
                    next_r.mem_wdata[OWN_BIT] = 1'b1;
                    next_r.state = ST_STAT;
                end
            end
            ST_STAT: begin
                if (mem_ack_in) begin
                    next_r.mem_wdata = r.status;
                    next_r.mem_wdata[OWN_BIT] = 1'b0;
                    next_r.state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (mem_ack_in) begin
                    ev[IRQ_DONE_BIT] = 1'b1;
                    ev[IRQ_ERR_BIT] = r.status[ERROR_SUMMARY_BIT];
                    if (r.ctrl[NEXT_POINTER_CHAIN_BIT]) begin
                        next_r.desc_ptr = align_desc(r.ba2);
                    end else begin
                        next_r.desc_ptr = r.desc_ptr + DESC_STRIDE;
                    end
                    next_r.mem_write = 1'b0;
                    next_r.word_idx = 2'h0;
                    next_r.mem_addr = next_r.desc_ptr + TX_DESC_STATUS_OFS;
                    next_r.mem_req = r.enable;
                    next_r.state = r.enable ? ST_FETCH : ST_IDLE;
                end
            end
        endcase

        // ****************************************
        // register port
        // ****************************************
        // register writes
        if (reg_write_in) begin
            unique case (reg_addr_in)
                REG_CTRL: next_r.enable = reg_wdata_in[CTRL_ENABLE_BIT];
                REG_POLL: next_r.poll_pend = 1'b1;
                REG_DESC_PTR: begin
                    if (r.state == ST_IDLE) begin
                        next_r.desc_ptr = align_desc(reg_wdata_in);
                    end
                end
                REG_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~reg_wdata_in[IRQ_W-1:0];
                REG_IRQ_MASK: next_r.irq_mask = reg_wdata_in[IRQ_W-1:0];
                default: ;
            endcase
        end
        // events win over a clear in the same cycle
        next_r.irq_stat = next_r.irq_stat | ev;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

        // ****************************************
        // register read data
        // ****************************************
        // register reads, data valid for one cycle only
        if (reg_read_in) begin
            unique case (reg_addr_in)
                REG_CTRL: next_r.rdata = {31'h0000_0000, r.enable};
                REG_DESC_PTR: next_r.rdata = r.desc_ptr;
                REG_IRQ_STAT: next_r.rdata = {29'h0000_0000, r.irq_stat};
                REG_IRQ_MASK: next_r.rdata = {29'h0000_0000, r.irq_mask};
                REG_STATE: next_r.rdata = {26'h0000_000, r.state};
                REG_LAST_STATUS: next_r.rdata = r.status;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.desc_ptr <= DESC_PTR_RESET;
            r.irq_mask <= IRQ_MASK_RESET;
            r.crc_append <= 1'b1;
            r.pad_enable <= 1'b1;
            r.buf2_valid <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_out = r.rdata;
    assign irq_out = r.irq;
    assign mem_req_out = r.mem_req;
    assign mem_write_out = r.mem_write;
    assign mem_addr_out = r.mem_addr;
    assign mem_wdata_out = r.mem_wdata;
    assign tx_start_out = r.tx_start;
    assign buffer_one_pointer_out = r.ba1;
    assign buffer_two_pointer_out = r.ba2;
    assign buffer_one_size_out = r.ctrl[TBS1_LSB +: TBS_W];
    assign buffer_two_size_out = r.ctrl[TBS2_LSB +: TBS_W];
    assign buffer_two_valid_out = r.buf2_valid;
    assign crc_append_out = r.crc_append;
    assign pad_enable_out = r.pad_enable;
    assign first_desc_out = r.ctrl[FS_BIT];
    assign last_desc_out = r.ctrl[LS_BIT];

endmodule : tdh_tx_desc

// File: verif/tdh_mem_model.sv
`timescale 1ns/1ps
module tdh_mem_model
    import tdh_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [1:0] delay_in,
    input wire logic mem_req_in,
    input wire logic mem_write_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] mem_wdata_in,
    output logic mem_ack_out,
    output logic [31:0] mem_rdata_out
);
    // ****************************************
    // host memory holding the descriptors
    // ****************************************
    logic [31:0] mem [0:255];
    logic [1:0] wait_cnt = 2'h0;
    initial begin
        mem_ack_out = 1'b0;
        mem_rdata_out = 32'h0;
    end
    // longword store, descriptors placed by the bench
    always @(posedge clock_in) begin
        mem_ack_out <= 1'b0;
        // read data toggles outside a read acknowledge
        mem_rdata_out <= ~mem_rdata_out;
        if (!resetn_in) begin
            wait_cnt <= 2'h0;
        end else if (mem_req_in && !mem_ack_out) begin
            if (wait_cnt == delay_in) begin
                mem_ack_out <= 1'b1;
                wait_cnt <= 2'h0;
                if (mem_write_in) begin
                    mem[mem_addr_in[9:2]] <= mem_wdata_in;
                end else begin
                    mem_rdata_out <= mem[mem_addr_in[9:2]];
                end
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : tdh_mem_model

// File: verif/tdh_tx_desc_asserts.sv
`timescale 1ns/1ps
module tdh_tx_desc_asserts
    import tdh_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic irq_out,
    input wire logic mem_req_out,
    input wire logic mem_write_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in,
    input wire logic tx_start_out,
    input wire logic [31:0] buffer_one_pointer_out,
    input wire logic [31:0] buffer_two_pointer_out,
    input wire logic buffer_two_valid_out,
    input wire logic crc_append_out,
    input wire logic pad_enable_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // ****************************************
    // descriptor words seen on the memory port
    // ****************************************
    logic [1:0] word_q;
    logic [31:0] ctl_q, w2_q, w3_q;
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            word_q <= 2'h0;
        end else if (mem_req_out && !mem_write_out && mem_ack_in) begin
            if (word_q != 2'h0 || mem_rdata_in[OWN_BIT]) word_q <= word_q + 2'h1;
            if (word_q == 2'h1) ctl_q <= mem_rdata_in;
            if (word_q == 2'h2) w2_q <= mem_rdata_in;
            if (word_q == 2'h3) w3_q <= mem_rdata_in;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
        && $stable(mem_wdata_out) && $stable(mem_write_out)) else $error("memory request changed before ack");
    rdata_zero_a: assert property (!reg_read_in |=> reg_rdata_out == 32'h0) else $error("read data not zero");
    start_pulse_a: assert property (tx_start_out |=> !tx_start_out) else $error("start longer than a cycle");
    start_delay_a: assert property (tx_start_out |-> $past(mem_ack_in, 5)) else $error("start not after fetch");
    desc_align_a: assert property (mem_req_out |-> mem_addr_out[1:0] == 2'h0) else $error("unaligned access");
    es_or_a: assert property (mem_req_out && mem_write_out |-> mem_wdata_out[15] == (mem_wdata_out[1]
        | mem_wdata_out[8] | mem_wdata_out[9] | mem_wdata_out[10] | mem_wdata_out[11] | mem_wdata_out[14]))
        else $error("error summary wrong");
    own_order_a: assert property (mem_req_out && mem_write_out && mem_wdata_out[31] && mem_ack_in
        |=> mem_req_out && mem_write_out && !mem_wdata_out[31] && $stable(mem_addr_out)
        && mem_wdata_out[30:0] == $past(mem_wdata_out[30:0])) else $error("ownership not returned");
    crc_pad_a: assert property (tx_start_out |-> crc_append_out == !ctl_q[26]
        && pad_enable_out == !ctl_q[23]) else $error("crc or pad flag wrong");
    chain_sel_a: assert property (tx_start_out |-> buffer_two_valid_out == !ctl_q[24])
        else $error("chain selection wrong");
    buf_ptr_a: assert property (tx_start_out |-> buffer_one_pointer_out == w2_q
        && (ctl_q[24] || buffer_two_pointer_out == w3_q)) else $error("buffer pointer wrong");
    chain_c: cover property (tx_start_out && !buffer_two_valid_out);
    release_c: cover property (mem_req_out && mem_write_out && !mem_wdata_out[31] && mem_ack_in);
    irq_c: cover property ($rose(irq_out));
endmodule : tdh_tx_desc_asserts

bind tdh_tx_desc tdh_tx_desc_asserts chk_u (.clock_in(clock_in), .resetn_in(resetn_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .mem_req_out(mem_req_out), .mem_write_out(mem_write_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .tx_start_out(tx_start_out), .buffer_one_pointer_out(buffer_one_pointer_out),
    .buffer_two_pointer_out(buffer_two_pointer_out), .buffer_two_valid_out(buffer_two_valid_out),
    .crc_append_out(crc_append_out), .pad_enable_out(pad_enable_out));

// File: verif/tx_descriptor_handler_bench.sv
`timescale 1ns/1ps
module tx_descriptor_handler_bench
    import tdh_pkg::*;
;
    logic clock_in = 1'b0, resetn_in = 1'b0, reg_write = 1'b0, reg_read = 1'b0, tx_done = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [13:0] st_flags = 14'h0;
    logic [1:0] delay = 2'h0;
    logic [31:0] rdata, mem_addr, mem_wdata, mem_rdata, bp1, bp2;
    logic [10:0] bs1, bs2;
    logic irq, mem_req, mem_write, mem_ack, tx_start, b2v, crc, pad, first, last;
    int mismatches = 0, compares = 0, cycles = 0;
    always #25 clock_in = ~clock_in;
    tdh_tx_desc dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(rdata), .irq_out(irq),
        .mem_req_out(mem_req), .mem_write_out(mem_write), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .tx_start_out(tx_start), .buffer_one_pointer_out(bp1),
        .buffer_two_pointer_out(bp2), .buffer_one_size_out(bs1), .buffer_two_size_out(bs2),
        .buffer_two_valid_out(b2v), .crc_append_out(crc), .pad_enable_out(pad), .first_desc_out(first),
        .last_desc_out(last), .tx_done_in(tx_done), .underrun_error_in(st_flags[13]),
        .underrun_count_in(st_flags[12:11]), .excess_collision_in(st_flags[10]), .late_collision_in(st_flags[9]),
        .no_carrier_in(st_flags[8]), .carrier_dropped_in(st_flags[7]), .jabber_timeout_in(st_flags[6]),
        .heartbeat_fail_in(st_flags[5]), .collision_count_in(st_flags[4:1]), .deferred_in(st_flags[0]));
    tdh_mem_model mem_u (.clock_in(clock_in), .resetn_in(resetn_in), .delay_in(delay), .mem_req_in(mem_req),
        .mem_write_in(mem_write), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata), .mem_ack_out(mem_ack),
        .mem_rdata_out(mem_rdata));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock_in);
        reg_write <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock_in);
        reg_read <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    task automatic put_desc(input logic [31:0] base, w0, w1, w2, w3);
        mem_u.mem[base[9:2]] = w0;
        mem_u.mem[base[9:2] + 8'h1] = w1;
        mem_u.mem[base[9:2] + 8'h2] = w2;
        mem_u.mem[base[9:2] + 8'h3] = w3;
    endtask : put_desc
    task automatic done(input logic [13:0] f);
        @(posedge clock_in);
        tx_done <= 1'b1;
        st_flags <= f;
        @(posedge clock_in);
        tx_done <= 1'b0;
        st_flags <= 14'h0;
    endtask : done
    task automatic frame(input logic [31:0] p1, p2, input logic [10:0] s1, s2, input logic [4:0] f);
        int n;
        n = 0;
        while (tx_start !== 1'b1 && n < 300) begin
            @(posedge clock_in);
            #1 n++;
        end
        chk("tx_start", 32'h1, {31'h0, tx_start});
        chk("buffer_one_pointer", p1, bp1);
        chk("buffer_two_pointer", p2, bp2);
        chk("sizes", {10'h0, s2, s1}, {10'h0, bs2, bs1});
        chk("frame_flags", {27'h0, f}, {27'h0, b2v, crc, pad, first, last});
    endtask : frame
    // ****************************************
    // scenarios
    // ****************************************
    task automatic reset_check;
        logic [31:0] v;
        #1 chk("reset_outputs", 32'h38, {26'h0, b2v, crc, pad, tx_start, mem_req, irq});
        reg_rd(REG_IRQ_MASK, v); chk("mask_reset", 32'h0, v);
        reg_rd(REG_DESC_PTR, v); chk("ptr_reset", 32'h0, v);
        reg_wr(8'h1C, 32'hFFFF_FFFF);
        reg_rd(8'h1C, v); chk("unmapped", 32'h0, v);
        done(14'h3FFF);
        reg_rd(REG_IRQ_STAT, v); chk("done_ignored", 32'h0, v);
        reg_rd(REG_STATE, v); chk("state_idle", 32'h1, v);
    endtask : reset_check
    task automatic chain_run(input logic [1:0] d);
        logic [31:0] v;
        int n;
        delay <= d;
        put_desc(32'h100, 32'h8000_0000, 32'h2401_0040, 32'h0000_1001, 32'h0000_2002);
        put_desc(32'h110, 32'h8000_0000, 32'h4180_07FF, 32'h0000_3003, 32'h0000_0203);
        put_desc(32'h200, 32'h0000_0000, 32'h0, 32'h0, 32'h0);
        reg_wr(REG_IRQ_MASK, 32'h0);
        reg_wr(REG_DESC_PTR, 32'h0000_0102);
        reg_rd(REG_DESC_PTR, v); chk("ptr_aligned", 32'h100, v);
        reg_wr(REG_CTRL, 32'h1);
        reg_wr(REG_POLL, 32'h1);
        frame(32'h1001, 32'h2002, 11'h040, 11'h020, 5'b10110);
        reg_rd(REG_STATE, v); chk("state_send", 32'h8, v);
        reg_wr(REG_DESC_PTR, 32'h300);
        reg_rd(REG_DESC_PTR, v); chk("ptr_locked", 32'h100, v);
        done(14'h0206);
        frame(32'h3003, 32'h0203, 11'h7FF, 11'h000, 5'b01001);
        done(14'h1001);
        n = 0;
        while (!(mem_ack === 1'b1 && mem_addr === 32'h200) && n < 400) begin
            @(posedge clock_in);
            #1 n++;
        end
        v = 32'h0;
        while (v !== 32'h1 && n < 400) begin
            reg_rd(REG_STATE, v);
            n++;
        end
        chk("idle_after_empty", 32'h1, v);
        chk("status_one", 32'h0000_8218, mem_u.mem[8'h40]);
        chk("status_two", 32'h0080_0001, mem_u.mem[8'h44]);
        reg_rd(REG_DESC_PTR, v); chk("chained_ptr", 32'h200, v);
        reg_rd(REG_LAST_STATUS, v); chk("last_status", 32'h0080_0001, v);
        reg_rd(REG_IRQ_STAT, v); chk("irq_status", 32'h7, v);
        chk("irq_masked", 32'h0, {31'h0, irq});
    endtask : chain_run
    task automatic irq_check;
        logic [31:0] v;
        reg_wr(REG_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clock_in);
        #1 chk("irq_unmasked", 32'h1, {31'h0, irq});
        reg_wr(REG_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clock_in);
        #1 chk("irq_cleared", 32'h0, {31'h0, irq});
        reg_rd(REG_IRQ_STAT, v); chk("irq_w1c", 32'h5, v);
        reg_wr(REG_IRQ_MASK, 32'h7);
        repeat (2) @(posedge clock_in);
        #1 chk("irq_all", 32'h1, {31'h0, irq});
        reg_wr(REG_IRQ_STAT, 32'h5);
        reg_rd(REG_IRQ_STAT, v); chk("irq_empty", 32'h0, v);
        #1 chk("irq_low", 32'h0, {31'h0, irq});
    endtask : irq_check
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge clock_in);
        resetn_in <= 1'b1;
        reset_check;
        chain_run(2'h0);
        reg_wr(REG_IRQ_STAT, 32'h7);
        chain_run(2'h3);
        irq_check;
        tally_and_finish;
    end
endmodule : tx_descriptor_handler_bench
